// ===== verilog/ppcc_pkg.sv
// Purpose: shared constants and types of the port power controller config block
// Assumes: 100 MHz clock, AXI4-Lite slave with 16-bit byte addresses
// Notes: register byte address is four times the register index
package ppcc_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int DRAIN_STEP_MS = 100;
  localparam int DRAIN_STEP_CYC = DRAIN_STEP_MS * (CLK_HZ / 1000);
  // 2000 mA high-load threshold
  localparam logic [11:0] HIGH_LOAD_MA = 12'h7D0;

  localparam int AW = 16;
  localparam logic [11:0] IDX_CFG1 = 12'h411;
  localparam logic [11:0] IDX_CFG3 = 12'h413;
  localparam logic [11:0] IDX_ILIM = 12'h414;
  localparam logic [11:0] IDX_ISTS = 12'h420;
  localparam logic [11:0] IDX_IMASK = 12'h421;
  localparam logic [AW-1:0] ADDR_CFG1 = {2'h0, IDX_CFG1, 2'h0};
  localparam logic [AW-1:0] ADDR_CFG3 = {2'h0, IDX_CFG3, 2'h0};
  localparam logic [AW-1:0] ADDR_ILIM = {2'h0, IDX_ILIM, 2'h0};
  localparam logic [AW-1:0] ADDR_ISTS = {2'h0, IDX_ISTS, 2'h0};
  localparam logic [AW-1:0] ADDR_IMASK = {2'h0, IDX_IMASK, 2'h0};

  localparam int CFG1_FILT = 7;
  localparam int CFG1_LINK = 6;
  localparam int CFG1_DRAIN = 5;
  localparam int CFG1_SWEN = 4;
  localparam int CFG1_DSEL = 2;
  localparam int CFG3_IGN = 7;
  localparam int CFG3_PST = 3;
  localparam int CFG3_HL = 2;
  localparam logic [1:0] DSEL_RST = 2'h1;
  localparam logic [2:0] ILIM_RST = 3'h3;
  localparam logic [2:0] STRAP_ILIM [0:3] = '{3'h1, 3'h3, 3'h5, 3'h7};

  localparam int IRQ_OC = 0;
  localparam int IRQ_TSD = 1;
  localparam int IRQ_LOW = 2;
  localparam int IRQ_ERR = 3;
  localparam int IRQ_DONE = 4;
  localparam int IRQ_W = 5;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [1:0] PST_SLEEP = 2'h0;
  localparam logic [1:0] PST_DETECT = 2'h1;
  localparam logic [1:0] PST_ACTIVE = 2'h2;
  localparam logic [1:0] PST_ERROR = 2'h3;

  typedef enum logic [1:0] {
    PS_SLEEP = 2'h0,
    PS_DETECT = 2'h1,
    PS_ACTIVE = 2'h3,
    PS_ERROR = 2'h2
  } ppcc_pstate_t;

  typedef struct packed {
    logic overcurrent;
    logic thermal;
    logic lowCurrent;
    logic otherError;
  } ppcc_flags_t;

  function automatic logic [1:0] ppcc_state_code(input ppcc_pstate_t s);
    case (s)
      PS_SLEEP: ppcc_state_code = PST_SLEEP;
      PS_DETECT: ppcc_state_code = PST_DETECT;
      PS_ACTIVE: ppcc_state_code = PST_ACTIVE;
      default: ppcc_state_code = PST_ERROR;
    endcase
  endfunction
endpackage

// ===== verilog/ppcc_port_power_ctrl.sv
// Purpose: config and state registers of a VBUS port power controller
// Assumes: inputs synchronous to clk; one write and one read in flight
// Notes: ce low freezes all state and stalls the bus
`timescale 1ns/1ps

module ppcc_port_power_ctrl #(
  parameter int DRAIN_STEP = ppcc_pkg::DRAIN_STEP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ppcc_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ppcc_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ppcc_pkg::ppcc_flags_t eventFlags,
  input wire logic switchEnablePin,
  input wire logic attachDetect,
  input wire logic standaloneMode,
  input wire logic powerCapabilityStrapA,
  input wire logic powerCapabilityStrapB,
  input wire logic [11:0] vbusCurrentMa,
  output logic portSwitchOn,
  output logic dischargeActive,
  output logic summaryAlert,
  output logic irq,
  output logic [1:0] controllerPowerState,
  output logic highLoadFlag,
  output logic [2:0] currentLimitSelect
);
  import ppcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt, wStrb0_r, wStrb0_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [AW-1:0] awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt, rdata_r, rdata_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic doWrite, rdTake, rdClear, rdHit, wrHit, wrCfg;
  logic [7:0] rdByte;

  logic filt_r, filt_nxt, link_r, link_nxt, swEnSoft_r, swEnSoft_nxt;
  logic ignore_r, ignore_nxt, strapDone_r, strapDone_nxt;
  logic [1:0] dsel_r, dsel_nxt;
  logic [2:0] ilim_r, ilim_nxt;
  logic [IRQ_W-1:0] mask_r, mask_nxt, ists_r, ists_nxt, istsSet;

  ppcc_pstate_t ps_r, ps_nxt;
  logic draining_r, draining_nxt, highLoad_r, highLoad_nxt;
  logic [31:0] drainCnt_r, drainCnt_nxt;
  logic enabled, fault, drainStart, drainDone;

  // bus stalls while frozen so no beat is taken and then lost
  assign s_axi_awready = ce & ~awHeld_r & ~bvalid_r;
  assign s_axi_wready = ce & ~wHeld_r & ~bvalid_r;
  assign s_axi_arready = ce & ~rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign doWrite = ce & awHeld_r & wHeld_r & ~bvalid_r;
  assign wrCfg = doWrite & wStrb0_r;
  assign rdTake = s_axi_arvalid & s_axi_arready;
  assign rdClear = rdTake & (s_axi_araddr == ADDR_ISTS);
  assign wrHit = (awAddr_r == ADDR_CFG1) | (awAddr_r == ADDR_CFG3) | (awAddr_r == ADDR_ILIM)
               | (awAddr_r == ADDR_ISTS) | (awAddr_r == ADDR_IMASK);

  always_comb begin
    rdHit = 1'b1;
    case (s_axi_araddr)
      ADDR_CFG1: rdByte = {filt_r, link_r, draining_r, swEnSoft_r, dsel_r, 2'h0};
      ADDR_CFG3: rdByte = {ignore_r, 2'h0, ppcc_state_code(ps_r), highLoad_r, 2'h0};
      ADDR_ILIM: rdByte = {5'h00, ilim_r};
      ADDR_ISTS: rdByte = {3'h0, ists_r};
      ADDR_IMASK: rdByte = {3'h0, mask_r};
      default: begin
        rdHit = 1'b0;
        rdByte = 8'h00;
      end
    endcase
  end

  always_comb begin
    awHeld_nxt = awHeld_r;
    awAddr_nxt = awAddr_r;
    wHeld_nxt = wHeld_r;
    wData_nxt = wData_r;
    wStrb0_nxt = wStrb0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_awvalid & s_axi_awready) begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid & s_axi_wready) begin
      wHeld_nxt = 1'b1;
      wData_nxt = s_axi_wdata;
      wStrb0_nxt = s_axi_wstrb[0];
    end
    if (doWrite) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wrHit ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_r & s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (rvalid_r & s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (rdTake) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = {24'h000000, rdByte};
      rresp_nxt = rdHit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
      wHeld_r <= 1'b0;
      wData_r <= 32'h00000000;
      wStrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else if (ce) begin
      awHeld_r <= awHeld_nxt;
      awAddr_r <= awAddr_nxt;
      wHeld_r <= wHeld_nxt;
      wData_r <= wData_nxt;
      wStrb0_r <= wStrb0_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    filt_nxt = filt_r;
    link_nxt = link_r;
    swEnSoft_nxt = swEnSoft_r;
    dsel_nxt = dsel_r;
    ignore_nxt = ignore_r;
    ilim_nxt = ilim_r;
    mask_nxt = mask_r;
    strapDone_nxt = 1'b1;
    if (wrCfg) begin
      case (awAddr_r)
        ADDR_CFG1: begin
          filt_nxt = wData_r[CFG1_FILT];
          link_nxt = wData_r[CFG1_LINK];
          swEnSoft_nxt = wData_r[CFG1_SWEN];
          dsel_nxt = wData_r[CFG1_DSEL +: 2];
        end
        ADDR_CFG3: ignore_nxt = wData_r[CFG3_IGN];
        ADDR_ILIM: begin
          if (ps_r != PS_SLEEP) begin
            ilim_nxt = wData_r[2:0];
          end
        end
        ADDR_IMASK: mask_nxt = wData_r[IRQ_W-1:0];
        default: ;
      endcase
    end
    // straps sampled on the first enabled cycle after reset release
    if (~strapDone_r & standaloneMode) begin
      ilim_nxt = STRAP_ILIM[{powerCapabilityStrapB, powerCapabilityStrapA}];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      filt_r <= 1'b0;
      link_r <= 1'b0;
      swEnSoft_r <= 1'b0;
      dsel_r <= DSEL_RST;
      ignore_r <= 1'b0;
      ilim_r <= ILIM_RST;
      mask_r <= '0;
      strapDone_r <= 1'b0;
    end else if (ce) begin
      filt_r <= filt_nxt;
      link_r <= link_nxt;
      swEnSoft_r <= swEnSoft_nxt;
      dsel_r <= dsel_nxt;
      ignore_r <= ignore_nxt;
      ilim_r <= ilim_nxt;
      mask_r <= mask_nxt;
      strapDone_r <= strapDone_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign enabled = swEnSoft_r | (switchEnablePin & ~ignore_r);
  assign fault = eventFlags.overcurrent | eventFlags.thermal;
  assign drainStart = wrCfg & (awAddr_r == ADDR_CFG1) & wData_r[CFG1_DRAIN]
                    & (ps_r == PS_ACTIVE) & ~draining_r;
  assign drainDone = draining_r & (drainCnt_r == 32'h00000000);
  assign istsSet = {drainDone, eventFlags.otherError, eventFlags.lowCurrent,
                    eventFlags.thermal, eventFlags.overcurrent};

  always_comb begin
    ps_nxt = ps_r;
    case (ps_r)
      PS_SLEEP: begin
        if (fault) ps_nxt = PS_ERROR;
        else if (enabled) ps_nxt = PS_DETECT;
      end
      PS_DETECT: begin
        if (fault) ps_nxt = PS_ERROR;
        else if (~enabled) ps_nxt = PS_SLEEP;
        else if (attachDetect) ps_nxt = PS_ACTIVE;
      end
      PS_ACTIVE: begin
        if (fault) ps_nxt = PS_ERROR;
        else if (~enabled) ps_nxt = PS_SLEEP;
        else if (~attachDetect) ps_nxt = PS_DETECT;
      end
      PS_ERROR: begin
        if (~fault) ps_nxt = enabled ? PS_DETECT : PS_SLEEP;
      end
      default: ps_nxt = PS_SLEEP;
    endcase
    draining_nxt = draining_r;
    drainCnt_nxt = drainCnt_r;
    if (drainStart) begin
      draining_nxt = 1'b1;
      // the duration written alongside the request is the one that counts
      drainCnt_nxt = 32'(DRAIN_STEP * (int'(dsel_nxt) + 1) - 1);
    end else if (drainDone) begin
      draining_nxt = 1'b0;
    end else if (draining_r) begin
      drainCnt_nxt = drainCnt_r - 32'h00000001;
    end
    // a new event in the clearing cycle survives the read
    ists_nxt = (rdClear ? '0 : ists_r) | istsSet;
    highLoad_nxt = vbusCurrentMa > HIGH_LOAD_MA;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ps_r <= PS_SLEEP;
      draining_r <= 1'b0;
      drainCnt_r <= 32'h00000000;
      ists_r <= '0;
      highLoad_r <= 1'b0;
    end else if (ce) begin
      ps_r <= ps_nxt;
      draining_r <= draining_nxt;
      drainCnt_r <= drainCnt_nxt;
      ists_r <= ists_nxt;
      highLoad_r <= highLoad_nxt;
    end
  end

  // switch is off for the whole drain, then follows enable again
  assign portSwitchOn = (ps_r == PS_ACTIVE) & enabled & ~draining_r;
  assign dischargeActive = draining_r;
  assign controllerPowerState = ppcc_state_code(ps_r);
  assign highLoadFlag = highLoad_r;
  assign currentLimitSelect = ilim_r;
  assign summaryAlert = ists_r[IRQ_OC] | ists_r[IRQ_TSD]
                      | (~filt_r & ists_r[IRQ_ERR]) | (link_r & ists_r[IRQ_LOW]);
  assign irq = |(ists_r & mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // helper: measure each drain against the duration chosen at its start
  logic [31:0] drainLen_r;
  logic [1:0] dselAtStart_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      drainLen_r <= 32'h00000000;
      dselAtStart_r <= 2'h0;
    end else if (ce) begin
      if (drainStart) begin
        drainLen_r <= 32'h00000000;
        dselAtStart_r <= dsel_nxt;
      end else if (draining_r) begin
        drainLen_r <= drainLen_r + 32'h00000001;
      end
    end
  end

  a_filter_alert: assert property (@(posedge clk) disable iff (rst)
    ce && eventFlags.overcurrent |=> summaryAlert)
    else $error("overcurrent did not raise alert");
  a_masked_other: assert property (@(posedge clk) disable iff (rst)
    filt_r && ists_r == (5'h01 << IRQ_ERR) |-> !summaryAlert)
    else $error("filtered error raised alert");
  a_join_alert: assert property (@(posedge clk) disable iff (rst)
    ce && link_r && !wrCfg && eventFlags.lowCurrent |=> summaryAlert)
    else $error("joined low current did not alert");
  a_join_off: assert property (@(posedge clk) disable iff (rst)
    !link_r && ists_r == (5'h01 << IRQ_LOW) |-> !summaryAlert)
    else $error("unjoined low current raised alert");
  a_drain_start: assert property (@(posedge clk) disable iff (rst)
    drainStart |=> draining_r && !portSwitchOn && dischargeActive)
    else $error("drain request did not open switch");
  a_drain_open: assert property (@(posedge clk) disable iff (rst)
    dischargeActive |-> !portSwitchOn)
    else $error("switch closed during drain");
  a_drain_len: assert property (@(posedge clk) disable iff (rst)
    $fell(draining_r) |-> drainLen_r == 32'(DRAIN_STEP * (int'(dselAtStart_r) + 1)))
    else $error("drain duration wrong");
  a_drain_end: assert property (@(posedge clk) disable iff (rst)
    ce && drainDone |=> !dischargeActive && ists_r[IRQ_DONE])
    else $error("drain did not release");
  a_switch_gate: assert property (@(posedge clk) disable iff (rst)
    portSwitchOn |-> swEnSoft_r || (switchEnablePin && !ignore_r))
    else $error("switch on without enable");
  a_pin_ignore: assert property (@(posedge clk) disable iff (rst)
    ce && ps_r == PS_SLEEP && ignore_r && !swEnSoft_r && !fault |=> ps_r == PS_SLEEP)
    else $error("ignored pin woke controller");
  a_state_code: assert property (@(posedge clk) disable iff (rst)
    ps_r == PS_ACTIVE |-> controllerPowerState == PST_ACTIVE)
    else $error("active state code wrong");
  a_state_follow: assert property (@(posedge clk) disable iff (rst)
    ce && ps_r == PS_SLEEP && enabled && !fault |=> controllerPowerState == PST_DETECT)
    else $error("state field not updated");
  a_high_load: assert property (@(posedge clk) disable iff (rst)
    ce && vbusCurrentMa > HIGH_LOAD_MA |=> highLoadFlag)
    else $error("high load not flagged");
  a_ilim_sleep: assert property (@(posedge clk) disable iff (rst)
    ce && strapDone_r && ps_r == PS_SLEEP |=> $stable(currentLimitSelect))
    else $error("limit changed in sleep");
  a_strap_load: assert property (@(posedge clk) disable iff (rst)
    ce && !strapDone_r && standaloneMode |=> currentLimitSelect
      == STRAP_ILIM[{$past(powerCapabilityStrapB), $past(powerCapabilityStrapA)}])
    else $error("strap limit not loaded");
endmodule // ppcc_port_power_ctrl

// ===== sim/ppcc_vbus_model.sv
// Purpose: far-side model of the VBUS power path and the attached device
// Assumes: bench commands attach, load current and fault levels
// Notes: flags and current lag the command by one clock
`timescale 1ns/1ps
module ppcc_vbus_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic portSwitchOn,
  input wire logic dischargeActive,
  input wire logic attachCmd,
  input wire logic [11:0] loadCmdMa,
  input wire ppcc_pkg::ppcc_flags_t faultCmd,
  output logic attachDetect,
  output logic [11:0] vbusCurrentMa,
  output ppcc_pkg::ppcc_flags_t eventFlags
);
  import ppcc_pkg::*;

  // no current while the switch is open or the rail is grounded: a live
  // reading there would hide a switch that fails to open
  always_ff @(posedge clk) begin
    if (rst) begin
      attachDetect <= 1'b0;
      vbusCurrentMa <= 12'h000;
      eventFlags <= '0;
    end else begin
      attachDetect <= attachCmd;
      vbusCurrentMa <= (portSwitchOn && !dischargeActive) ? loadCmdMa : 12'h000;
      eventFlags <= faultCmd;
    end
  end
endmodule // ppcc_vbus_model

// ===== sim/ppcc_port_power_ctrl_tb.sv
// Purpose: self-checking bench of the port power controller config block
// Assumes: drain step shortened to STEP cycles
// Notes: bus ready and answers are sampled at the falling edge
`timescale 1ns/1ps
module ppcc_port_power_ctrl_tb;
  import ppcc_pkg::*;
  localparam int STEP = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [AW-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic pin = 1'b0, attachCmd = 1'b0, strapA = 1'b0, strapB = 1'b0, standalone = 1'b1;
  logic [11:0] loadMa = 12'h000;
  logic [11:0] vbusCurrentMa, v;
  ppcc_flags_t faultCmd = '0;
  ppcc_flags_t eventFlags;
  logic attachDetect, portSwitchOn, dischargeActive, summaryAlert, irq, highLoadFlag;
  logic [1:0] controllerPowerState;
  logic [2:0] currentLimitSelect, code, strap;
  int errors = 0, cmp_count = 0, drainCnt = 0, i, n;

  always #5 clk = ~clk;

  ppcc_port_power_ctrl #(.DRAIN_STEP(STEP)) i_ppcc_port_power_ctrl (
    .clk(clk), .rst(rst), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .eventFlags(eventFlags), .switchEnablePin(pin), .attachDetect(attachDetect),
    .standaloneMode(standalone), .powerCapabilityStrapA(strapA), .powerCapabilityStrapB(strapB),
    .vbusCurrentMa(vbusCurrentMa), .portSwitchOn(portSwitchOn),
    .dischargeActive(dischargeActive), .summaryAlert(summaryAlert), .irq(irq),
    .controllerPowerState(controllerPowerState), .highLoadFlag(highLoadFlag),
    .currentLimitSelect(currentLimitSelect));

  ppcc_vbus_model i_ppcc_vbus_model (
    .clk(clk), .rst(rst), .portSwitchOn(portSwitchOn), .dischargeActive(dischargeActive),
    .attachCmd(attachCmd), .loadCmdMa(loadMa), .faultCmd(faultCmd),
    .attachDetect(attachDetect), .vbusCurrentMa(vbusCurrentMa), .eventFlags(eventFlags));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // valids drop at the edge after ready was seen; bready stays up until bvalid
  task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 200; k++) begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      rsp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
        return;
      end
    end
    errors++;
    conclude();
  endtask

  task automatic axR(input logic [AW-1:0] a);
    logic ta, tr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 200; k++) begin
      @(negedge clk);
      ta = arvalid & arready;
      tr = rvalid;
      rd = rdata;
      rsp = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        return;
      end
    end
    errors++;
    conclude();
  endtask

  task automatic rdChk(input string what, input logic [AW-1:0] a, input logic [7:0] exp);
    axR(a);
    chk(what, {24'h000000, exp}, rd);
  endtask

  task automatic waitSt(input logic [1:0] exp);
    for (n = 0; n < 20 && controllerPowerState !== exp; n++) @(negedge clk);
    chk("power state", {30'h0, exp}, {30'h0, controllerPowerState});
    if (n == 20) conclude();
  endtask

  function automatic logic alertExp(input logic f, input logic j, input ppcc_flags_t e);
    return e.overcurrent | e.thermal | (!f & e.otherError) | (j & e.lowCurrent);
  endfunction

  always @(negedge clk) begin
    if (dischargeActive === 1'b1) begin
      drainCnt++;
      chk("switch while draining", 32'h0, {31'h0, portSwitchOn});
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hc77c135e));
    {strapB, strapA} = 2'($urandom);
    strap = STRAP_ILIM[{strapB, strapA}];
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdChk("cfg1 reset", ADDR_CFG1, 8'h04);
    rdChk("cfg3 reset", ADDR_CFG3, 8'h00);
    rdChk("limit from straps", ADDR_ILIM, {5'h00, strap});
    wr(ADDR_ILIM, {5'h00, ~strap});
    rdChk("limit in sleep", ADDR_ILIM, {5'h00, strap});
    pin <= 1'b1;
    waitSt(PST_DETECT);
    wr(ADDR_CFG3, 8'h80);
    waitSt(PST_SLEEP);
    wr(ADDR_CFG3, 8'h00);
    pin <= 1'b0;
    waitSt(PST_SLEEP);
    wr(ADDR_CFG1, 8'h14);
    waitSt(PST_DETECT);
    chk("switch in detect", 32'h0, {31'h0, portSwitchOn});
    attachCmd <= 1'b1;
    waitSt(PST_ACTIVE);
    chk("switch in active", 32'h1, {31'h0, portSwitchOn});
    rdChk("cfg3 state", ADDR_CFG3, 8'h10);
    // frozen block must ignore a detach and refuse bus requests
    ce <= 1'b0;
    attachCmd <= 1'b0;
    repeat (4) @(posedge clk);
    chk("frozen state", {30'h0, PST_ACTIVE}, {30'h0, controllerPowerState});
    chk("frozen arready", 32'h0, {31'h0, arready});
    attachCmd <= 1'b1;
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    for (i = 0; i < 4; i++) begin
      code = 3'($urandom);
      wr(ADDR_ILIM, {5'h00, code});
      rdChk("limit code", ADDR_ILIM, {5'h00, code});
      chk("limit port", {29'h0, code}, {29'h0, currentLimitSelect});
    end
    for (i = 0; i < 5; i++) begin
      v = (i == 0) ? 12'h7D0 : (i == 1) ? 12'h7D1 : 12'($urandom);
      loadMa <= v;
      repeat (4) @(negedge clk);
      chk("high load", {31'h0, v > HIGH_LOAD_MA}, {31'h0, highLoadFlag});
      rdChk("cfg3 high load", ADDR_CFG3, {5'h02, v > HIGH_LOAD_MA, 2'h0});
    end
    loadMa <= 12'h000;
    wr(ADDR_IMASK, 8'h10);
    for (i = 0; i < 4; i++) begin
      drainCnt = 0;
      wr(ADDR_CFG1, 8'h30 | 8'(i << 2));
      for (n = 0; n < 300 && dischargeActive !== 1'b0; n++) @(negedge clk);
      if (n == 300) begin
        errors++;
        conclude();
      end
      chk("drain cycles", (i + 1) * STEP, drainCnt);
      repeat (2) @(negedge clk);
      chk("switch after drain", 32'h1, {31'h0, portSwitchOn});
      chk("done irq", 32'h1, {31'h0, irq});
      rdChk("drain self clear", ADDR_CFG1, 8'h10 | 8'(i << 2));
      rdChk("done status", ADDR_ISTS, 8'h10);
      chk("irq cleared", 32'h0, {31'h0, irq});
    end
    wr(ADDR_IMASK, 8'h08);
    for (i = 0; i < 8; i++) begin
      wr(ADDR_CFG1, {i[0], i[1], 6'h1C});
      faultCmd <= i[2] ? 4'h2 : 4'h1;
      @(posedge clk);
      faultCmd <= 4'h0;
      repeat (4) @(negedge clk);
      chk("alert", {31'h0, alertExp(i[0], i[1], i[2] ? 4'h2 : 4'h1)},
          {31'h0, summaryAlert});
      chk("irq mask", {31'h0, !i[2]}, {31'h0, irq});
      rdChk("event status", ADDR_ISTS, i[2] ? 8'h04 : 8'h08);
      chk("alert cleared", 32'h0, {31'h0, summaryAlert});
    end
    wr(ADDR_CFG1, 8'h9C);
    faultCmd <= 4'h8;
    waitSt(PST_ERROR);
    chk("alert on overcurrent", 32'h1, {31'h0, summaryAlert});
    rdChk("cfg3 error", ADDR_CFG3, 8'h18);
    faultCmd <= 4'h0;
    // second reset without straps: limit falls back to its plain reset code
    rst <= 1'b1;
    standalone <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdChk("limit without straps", ADDR_ILIM, {5'h00, ILIM_RST});
    rdChk("cfg3 after reset", ADDR_CFG3, 8'h00);
    axR(16'h0000);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    chk("unmapped data", 32'h0, rd);
    conclude();
  end
endmodule // ppcc_port_power_ctrl_tb
